// ===== fwps_pkg.sv
// Constants shared by the flash write-protect and status block
package fwps_pkg;
  // System clock and power-up write delay
  localparam int CLK_MHZ     = 100;
  localparam int PUW_TIME_US = 10;
  localparam int PUW_CYC     = PUW_TIME_US * CLK_MHZ;
  // Operation lengths in system cycles (plain defaults, no timing given)
  localparam int PP_CYC      = 64;
  localparam int SE_CYC      = 256;
  localparam int BE_CYC      = 512;
  localparam int CE_CYC      = 1024;
  localparam int WRSR_CYC    = 128;
  localparam int ADDR_W      = 20;

  // Instruction codes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR1  = 8'h05;
  localparam logic [7:0] OP_RDSR2  = 8'h35;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_QPP    = 8'h32;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hd8;
  localparam logic [7:0] OP_CE_A   = 8'hc7;
  localparam logic [7:0] OP_CE_B   = 8'h60;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_PD     = 8'hb9;
  localparam logic [7:0] OP_RPD    = 8'hab;

  // Status bit positions
  localparam int S_BUSY = 0;
  localparam int S_WEL  = 1;
  localparam int S_BP0  = 2;
  localparam int S_TB   = 5;
  localparam int S_SEC  = 6;
  localparam int S_STATUS_LOCK_BIT0 = 7;
  localparam int S_STATUS_LOCK_BIT1 = 8;
  localparam int S_QE   = 9;
  localparam int S_CMP  = 14;
  localparam int S_SUS  = 15;

  // Non-volatile bits: reset value and the bits a status write may change
  localparam logic [15:0] NV_RST     = 16'h0000;
  localparam logic [15:0] NV_WR_MASK = 16'h43fc;

  // Region sizes as powers of two
  localparam int PAGE_LG  = 8;
  localparam int SECT_LG  = 12;
  localparam int BLK32_LG = 15;
  localparam int BLK_LG   = 16;
  localparam int SECT_CAP = 15;

  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL  = 3'h7;
  localparam logic [2:0] BYTES_FULL = 3'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSP} fwps_op_e;
endpackage

// ===== fwps_top.sv
// Serial flash write-protect, status register and instruction gating
`timescale 1ns/10ps
module fwps_top #(
  parameter int ADDR_W   = fwps_pkg::ADDR_W,
  parameter int PUW_CYC  = fwps_pkg::PUW_CYC,
  parameter int PP_CYC   = fwps_pkg::PP_CYC,
  parameter int SE_CYC   = fwps_pkg::SE_CYC,
  parameter int BE_CYC   = fwps_pkg::BE_CYC,
  parameter int CE_CYC   = fwps_pkg::CE_CYC,
  parameter int WRSR_CYC = fwps_pkg::WRSR_CYC
) (
  input  wire logic        clk_sys,     // System clock, 100 MHz
  input  wire logic        rst_n,       // Supply-level reset, async
  input  wire logic        nv_rst_n,    // Factory reset of non-volatile bits
  input  wire logic        sclk,        // Serial bus clock
  input  wire logic        cs_n,        // Chip select pin
  input  wire logic        di,          // Serial data in
  input  wire logic        wp_n,        // Write-protect pin
  output logic             do_o,        // Serial data out
  output logic             do_oe,       // Data out enable
  output logic [15:0]      status_o,    // Full status word
  output logic             power_down_o // Power-down state
);
  localparam int TMR_W = 24;

  generate
    if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_aw
      $error("ADDR_W must be 16..24");
    end
    if (PUW_CYC < 1 || PUW_CYC >= (1 << TMR_W) || CE_CYC >= (1 << TMR_W) || PP_CYC < 1
        || SE_CYC < 1 || BE_CYC < 1 || CE_CYC < 1 || WRSR_CYC < 1) begin : g_bad_cnt
      $error("cycle counts out of range");
    end
  endgenerate

  // ---------------- serial clock domain ----------------
  logic        link_rst_n;
  logic [2:0]  bit_cnt_q;
  logic [6:0]  shift_q;
  logic        first_done_q;
  logic        rd_lo_q;
  logic        rd_hi_q;
  logic [7:0]  byte_q;
  logic        byte_tgl_q;
  logic [15:0] stat_s1_q;
  logic [15:0] stat_s2_q;
  logic [7:0]  rd_byte;

  // Frame logic restarts whenever select is high
  assign link_rst_n = rst_n & ~cs_n;

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q    <= 3'h0;
      shift_q      <= 7'h00;
      first_done_q <= 1'b0;
      rd_lo_q      <= 1'b0;
      rd_hi_q      <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], di};
      if (bit_cnt_q == 3'h7 && !first_done_q) begin
        first_done_q <= 1'b1;
        rd_lo_q      <= ({shift_q, di} == fwps_pkg::OP_RDSR1);
        rd_hi_q      <= ({shift_q, di} == fwps_pkg::OP_RDSR2);
      end
    end
  end

  // Byte and its toggle survive deselect so no false event is made
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_q     <= 8'h00;
      byte_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == 3'h7) begin
      byte_q     <= {shift_q, di};
      byte_tgl_q <= ~byte_tgl_q;
    end
  end

  // Status bits synchronised per bit; busy, latch and written bits move together,
  // a read that straddles completion may show one of them a byte late
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_s1_q <= 16'h0000;
      stat_s2_q <= 16'h0000;
    end else begin
      stat_s1_q <= status_o;
      stat_s2_q <= stat_s1_q;
    end
  end

  assign rd_byte = rd_hi_q ? stat_s2_q[15:8] : stat_s2_q[7:0];

  // Status read answers on falling edges, repeating the byte
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      do_o  <= 1'b0;
      do_oe <= 1'b0;
    end else begin
      do_oe <= rd_lo_q | rd_hi_q;
      do_o  <= rd_byte[3'h7 - bit_cnt_q];
    end
  end

  // ---------------- system clock domain ----------------
  logic [2:0]  tgl_sync_q;
  logic [3:0]  cs_sync_q;
  logic [1:0]  wp_sync_q;
  logic        byte_ev;
  logic        frame_end;
  logic [2:0]  nbytes_q;
  logic [7:0]  op_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic [7:0]  b3_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_q <= 3'h0;
      cs_sync_q  <= 4'hf;
      wp_sync_q  <= 2'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], byte_tgl_q};
      cs_sync_q  <= {cs_sync_q[2:0], cs_n};
      wp_sync_q  <= {wp_sync_q[0], wp_n};
    end
  end

  // Select is delayed one stage more so the last byte lands first
  assign byte_ev   = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign frame_end = cs_sync_q[2] & ~cs_sync_q[3];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nbytes_q <= 3'h0;
      op_q     <= 8'h00;
      b1_q     <= 8'h00;
      b2_q     <= 8'h00;
      b3_q     <= 8'h00;
    end else if (cs_sync_q[3] && !byte_ev) begin
      nbytes_q <= 3'h0;
    end else if (byte_ev && nbytes_q != fwps_pkg::BYTES_FULL) begin
      nbytes_q <= nbytes_q + 3'h1;
      unique case (nbytes_q)
        3'h0:    op_q <= byte_q;
        3'h1:    b1_q <= byte_q;
        3'h2:    b2_q <= byte_q;
        default: b3_q <= byte_q;
      endcase
    end
  end

  // Power-up delay and first-cycle boot flag
  logic [TMR_W-1:0] puw_cnt_q;
  logic             pu_done_q;
  logic             boot_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      puw_cnt_q <= '0;
      pu_done_q <= 1'b0;
      boot_q    <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (!pu_done_q) begin
        puw_cnt_q <= puw_cnt_q + 1'b1;
        pu_done_q <= (puw_cnt_q == TMR_W'(PUW_CYC - 1));
      end
    end
  end

  // Protection check of a target range against the protect bits
  function automatic logic prot_blocked(input logic [2:0] bp, input logic tb,
                                        input logic sec, input logic cmp,
                                        input logic [ADDR_W:0] lo,
                                        input logic [ADDR_W:0] hi);
    logic [ADDR_W:0] full;
    logic [ADDR_W:0] sz;
    logic [ADDR_W:0] rlo;
    logic [ADDR_W:0] rhi;
    int              lg;
    full = (ADDR_W+1)'(1) << ADDR_W;
    lg   = (sec ? fwps_pkg::SECT_LG : fwps_pkg::BLK_LG) + int'(bp) - 1;
    if (sec && lg > fwps_pkg::SECT_CAP) lg = fwps_pkg::SECT_CAP;
    if (!sec && lg > ADDR_W - 1) lg = ADDR_W - 1;
    if (bp == fwps_pkg::BP_NONE) sz = '0;
    else if (bp == fwps_pkg::BP_ALL) sz = full;
    else sz = (ADDR_W+1)'(1) << lg;
    rlo = tb ? '0 : full - sz;
    rhi = tb ? sz : full;
    if (cmp) return !(lo >= rlo && hi <= rhi && sz != '0);
    return (sz != '0) && (lo < rhi) && (hi > rlo);
  endfunction

  // Non-volatile bits and operation control
  logic [15:0]      nv_q;
  logic [15:0]      nv_new_q;
  logic [15:0]      nv_d;
  fwps_pkg::fwps_op_e state_q;
  logic [TMR_W-1:0] tmr_q;
  logic             wel_q;
  logic             sus_q;
  logic             pd_q;
  logic             wrsr_q;
  logic             wr_done;

  logic [1:0]       srp;
  logic             sr_allow;
  logic             is_write_op;
  logic [ADDR_W:0]  t_lo;
  logic [ADDR_W:0]  t_hi;
  logic [TMR_W-1:0] t_len;
  logic             need_addr;
  logic             blocked;
  logic [ADDR_W-1:0] addr;
  logic [23:0]      addr_all;
  int               t_lg;

  assign srp     = {nv_q[fwps_pkg::S_STATUS_LOCK_BIT1], nv_q[fwps_pkg::S_STATUS_LOCK_BIT0]};
  assign wr_done = (state_q == fwps_pkg::ST_RUN) && (tmr_q == '0);
  assign addr_all = {b1_q, b2_q, b3_q};

  always_comb begin
    // Pin counts only in mode 01 and only while quad is off
    unique case (srp)
      2'b00:   sr_allow = 1'b1;
      2'b01:   sr_allow = wp_sync_q[1] | nv_q[fwps_pkg::S_QE];
      default: sr_allow = 1'b0;
    endcase
  end

  always_comb begin
    addr        = addr_all[ADDR_W-1:0];
    is_write_op = 1'b1;
    need_addr   = 1'b1;
    t_lg        = fwps_pkg::PAGE_LG;
    t_len       = TMR_W'(PP_CYC);
    unique case (op_q)
      fwps_pkg::OP_PP, fwps_pkg::OP_QPP: begin
        t_lg  = fwps_pkg::PAGE_LG;
        t_len = TMR_W'(PP_CYC);
      end
      fwps_pkg::OP_SE: begin
        t_lg  = fwps_pkg::SECT_LG;
        t_len = TMR_W'(SE_CYC);
      end
      fwps_pkg::OP_BE32: begin
        t_lg  = fwps_pkg::BLK32_LG;
        t_len = TMR_W'(BE_CYC);
      end
      fwps_pkg::OP_BE64: begin
        t_lg  = fwps_pkg::BLK_LG;
        t_len = TMR_W'(BE_CYC);
      end
      fwps_pkg::OP_CE_A, fwps_pkg::OP_CE_B: begin
        t_lg      = ADDR_W;
        t_len     = TMR_W'(CE_CYC);
        need_addr = 1'b0;
      end
      default: is_write_op = 1'b0;
    endcase
    t_lo = {1'b0, (addr >> t_lg) << t_lg};
    t_hi = t_lo + ((ADDR_W+1)'(1) << t_lg);
    blocked = prot_blocked(nv_q[fwps_pkg::S_BP0 +: 3], nv_q[fwps_pkg::S_TB],
                           nv_q[fwps_pkg::S_SEC], nv_q[fwps_pkg::S_CMP],
                           t_lo, t_hi);
  end

  // Operation state, latch, suspend and power-down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= fwps_pkg::ST_IDLE;
      tmr_q    <= '0;
      wel_q    <= 1'b0;
      sus_q    <= 1'b0;
      pd_q     <= 1'b0;
      wrsr_q   <= 1'b0;
      nv_new_q <= 16'h0000;
    end else if (wr_done) begin
      state_q <= fwps_pkg::ST_IDLE;
      wel_q   <= 1'b0;
      wrsr_q  <= 1'b0;
    end else begin
      if (state_q == fwps_pkg::ST_RUN) tmr_q <= tmr_q - 1'b1;
      if (frame_end && nbytes_q != 3'h0) begin
        if (pd_q) begin
          if (op_q == fwps_pkg::OP_RPD && state_q != fwps_pkg::ST_RUN) pd_q <= 1'b0;
        end else if (state_q == fwps_pkg::ST_RUN) begin
          // Only suspend acts here; status reads are served by the link side
          if (op_q == fwps_pkg::OP_SUSP && !wrsr_q) begin
            state_q <= fwps_pkg::ST_SUSP;
            sus_q   <= 1'b1;
          end
        end else begin
          unique case (op_q)
            fwps_pkg::OP_WREN:  if (pu_done_q) wel_q <= 1'b1;
            fwps_pkg::OP_WRDI:  wel_q <= 1'b0;
            fwps_pkg::OP_PD:    pd_q  <= 1'b1;
            fwps_pkg::OP_RESUME: if (state_q == fwps_pkg::ST_SUSP) begin
              state_q <= fwps_pkg::ST_RUN;
              sus_q   <= 1'b0;
            end
            fwps_pkg::OP_WRSR: begin
              // Refused write leaves everything as it was
              if (state_q == fwps_pkg::ST_IDLE && pu_done_q && wel_q && sr_allow
                  && nbytes_q >= 3'h2) begin
                state_q  <= fwps_pkg::ST_RUN;
                tmr_q    <= TMR_W'(WRSR_CYC - 1);
                wrsr_q   <= 1'b1;
                nv_new_q <= {(nbytes_q >= 3'h3) ? b2_q : nv_q[15:8], b1_q};
              end
            end
            default: begin
              if (is_write_op && state_q == fwps_pkg::ST_IDLE && pu_done_q && wel_q
                  && !blocked && (!need_addr || nbytes_q == fwps_pkg::BYTES_FULL)) begin
                state_q <= fwps_pkg::ST_RUN;
                tmr_q   <= t_len - 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // Next non-volatile value; the status word shows it on the same edge as busy falls
  always_comb begin
    nv_d = nv_q;
    if (boot_q && srp == 2'b10) begin
      nv_d[fwps_pkg::S_STATUS_LOCK_BIT1] = 1'b0;
    end else if (wr_done && wrsr_q) begin
      nv_d = (nv_q & ~fwps_pkg::NV_WR_MASK) | (nv_new_q & fwps_pkg::NV_WR_MASK);
    end
  end

  // Non-volatile store: survives supply reset; lock-down clears at power-up
  always_ff @(posedge clk_sys or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      nv_q <= fwps_pkg::NV_RST;
    end else if (!rst_n) begin
      nv_q <= nv_q;
    end else begin
      nv_q <= nv_d;
    end
  end

  // Status word and flags, all from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_o     <= 16'h0000;
      power_down_o <= 1'b0;
    end else begin
      status_o <= nv_d;
      status_o[fwps_pkg::S_BUSY] <= (state_q == fwps_pkg::ST_RUN) && !wr_done;
      status_o[fwps_pkg::S_WEL]  <= wel_q && !wr_done;
      status_o[fwps_pkg::S_SUS]  <= sus_q;
      power_down_o <= pd_q;
    end
  end
endmodule

// ===== fwps_checker.sv
// Assertion checker for the flash write-protect and status block
`timescale 1ns/10ps
module fwps_checker #(
  parameter int PUW_CYC = 1000
) (
  input wire logic        clk_sys,      // System clock
  input wire logic        rst_n,        // Supply reset, active low
  input wire logic [15:0] status_o,     // Status word
  input wire logic        power_down_o  // Power-down state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Saturating count of cycles since supply reset release
  logic [15:0] puw_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) puw_q <= 16'h0000;
    else if (puw_q < 16'(PUW_CYC)) puw_q <= puw_q + 16'h0001;
  end

  property p_pu_clear; $rose(rst_n) |-> status_o[1:0] == 2'b00 && !status_o[15]; endproperty
  a_pu_clear: assert property (p_pu_clear) else $error("busy or latch set at power-up");
  property p_puw; puw_q < 16'(PUW_CYC) |-> !$rose(status_o[1]); endproperty
  a_puw: assert property (p_puw) else $error("latch set inside power-up delay");
  property p_busy_wel; $rose(status_o[0]) |-> status_o[1]; endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("write started without latch");
  property p_done_wel; $fell(status_o[0]) && !status_o[15] |-> !status_o[1]; endproperty
  a_done_wel: assert property (p_done_wel) else $error("latch kept after completion");
  property p_wel_gate; $rose(status_o[1]) |-> !$past(status_o[0]) && !power_down_o; endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("enable taken while busy or down");
  property p_nv_done; $changed(status_o[14:2]) && $past(rst_n, 2) |-> $fell(status_o[0]); endproperty
  a_nv_done: assert property (p_nv_done) else $error("protect bits changed outside a write");
  property p_srp_lock; status_o[8] |=> $stable(status_o[14:2]); endproperty
  a_srp_lock: assert property (p_srp_lock) else $error("locked status word changed");
  property p_busy_hold; $rose(status_o[0]) && !$past(status_o[15]) |=> status_o[0] [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped too early");
  property p_sus; $rose(status_o[15]) |-> !status_o[0] && $past(status_o[0]); endproperty
  a_sus: assert property (p_sus) else $error("suspend flag without halted operation");

  c_busy: cover property ($rose(status_o[0]));
  c_sus: cover property ($rose(status_o[15]));
  c_pd: cover property ($rose(power_down_o));
endmodule

bind fwps_top fwps_checker #(.PUW_CYC(PUW_CYC)) chk_u (
  .clk_sys      (clk_sys),
  .rst_n        (rst_n),
  .status_o     (status_o),
  .power_down_o (power_down_o)
);

// ===== fwps_host.sv
// Host serial controller model driving instruction frames, mode 0
`timescale 1ns/10ps
module fwps_host #(
  parameter int HALF_NS = 24
) (
  output logic      sclk, // Serial clock, still between frames
  output logic      cs_n, // Chip select
  output logic      di,   // Serial data to the device
  input  wire logic do_o, // Serial data from the device
  input  wire logic do_oe // Output enable from the device
);
  logic oe_last; // Output enable seen at the last rising edge
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di   = 1'b0;
    oe_last = 1'b0;
  end

  // Sends nb bits of tx MSB first; rx keeps the last eight bits read back
  task automatic frame(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      di = tx[i];
      #(HALF_NS) sclk = 1'b1;
      rx = {rx[6:0], do_o};
      oe_last = do_oe;
      #(HALF_NS) sclk = 1'b0;
    end
    #(HALF_NS) cs_n = 1'b1;
    di = ~di; // Released line must not hold a stale bit
    #100;
  endtask
endmodule

// ===== fwps_top_tb_top.sv
// Self-checking bench for the flash write-protect and status block
`timescale 1ns/10ps
module fwps_top_tb_top;
  localparam int PUW = 200;
  logic        clk_sys, rst_n, nv_rst_n, wp_n, sclk, cs_n, di, do_o, do_oe, pd;
  logic [15:0] status_o;
  logic [7:0]  rd;
  int          err_total, tests_run;

  // Long status write so that a whole read frame fits inside the busy time
  fwps_top #(.PUW_CYC(PUW), .PP_CYC(400), .WRSR_CYC(400)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .nv_rst_n(nv_rst_n), .sclk(sclk), .cs_n(cs_n),
    .di(di), .wp_n(wp_n), .do_o(do_o), .do_oe(do_oe), .status_o(status_o), .power_down_o(pd));
  fwps_host host_u (.sclk(sclk), .cs_n(cs_n), .di(di), .do_o(do_o), .do_oe(do_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Samples at the falling edge so that no update is racing the check
  task automatic st(input logic [15:0] exp);
    @(negedge clk_sys);
    chk("status", status_o, exp);
  endtask
  task automatic pdc(input logic e);
    @(negedge clk_sys);
    chk("power_down", {15'h0000, pd}, {15'h0000, e});
  endtask
  task automatic sf(input logic [39:0] tx, input int nb);
    logic [7:0] d;
    host_u.frame(tx, nb, d);
  endtask
  // Enable first, then status write of low and high byte
  task automatic wrsr(input logic [15:0] v);
    sf(40'h06, 8);
    sf({16'h0000, 8'h01, v[7:0], v[15:8]}, 24);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (status_o[0] !== 1'b0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic setwp(input logic v);
    @(posedge clk_sys) wp_n <= v;
    @(negedge clk_sys);
  endtask
  task automatic pwr();
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (PUW + 5) @(negedge clk_sys);
  endtask

  initial begin
    err_total = 0;
    tests_run = 0;
    rst_n = 1'b0;
    nv_rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    pdc(1'b0);
    st(16'h0000);
    @(posedge clk_sys);
    nv_rst_n <= 1'b1;
    rst_n <= 1'b1;
    st(16'h0000);
    sf(40'h06, 8);
    st(16'h0000);
    repeat (PUW) @(negedge clk_sys);
    sf(40'h0180, 16);
    st(16'h0000);
    sf(40'h06, 8);
    host_u.frame(40'h0500, 16, rd);
    chk("read_low", {8'h00, rd}, 16'h0002);
    chk("read_enable", {15'h0000, host_u.oe_last}, 16'h0001);
    wrsr(16'h001c);
    st(16'h0003);
    chk("write_enable_off", {15'h0000, host_u.oe_last}, 16'h0000);
    sf(40'hb9, 8);
    host_u.frame(40'h0500, 16, rd);
    chk("read_busy", {8'h00, rd}, 16'h0003);
    pdc(1'b0);
    idle();
    st(16'h001c);
    sf(40'h06, 8);
    sf(40'h02000000a5, 40);
    st(16'h001e);
    wrsr(16'h4064);
    idle();
    st(16'h4064);
    host_u.frame(40'h3500, 16, rd);
    chk("read_high", {8'h00, rd}, 16'h0040);
    sf(40'h06, 8);
    sf(40'h02001000a5, 40);
    st(16'h4066);
    sf(40'h02000100a5, 40);
    st(16'h4067);
    sf(40'h75, 8);
    st(16'hc066);
    sf(40'h7a, 8);
    st(16'h4067);
    idle();
    st(16'h4064);
    wrsr(16'h0080);
    idle();
    st(16'h0080);
    setwp(1'b0);
    wrsr(16'h0084);
    st(16'h0082);
    setwp(1'b1);
    wrsr(16'h0084);
    idle();
    st(16'h0084);
    wrsr(16'h0280);
    idle();
    setwp(1'b0);
    wrsr(16'h0288);
    idle();
    st(16'h0288);
    wrsr(16'h0100);
    idle();
    st(16'h0100);
    wrsr(16'h0004);
    st(16'h0102);
    pwr();
    st(16'h0000);
    sf(40'hb9, 8);
    pdc(1'b1);
    sf(40'h06, 8);
    st(16'h0000);
    sf(40'hab, 8);
    pdc(1'b0);
    sf(40'h06, 8);
    st(16'h0002);
    sf(40'h04, 8);
    st(16'h0000);
    sf(40'h06, 8);
    sf(40'h20000000, 32);
    st(16'h0003);
    idle();
    st(16'h0000);
    sf(40'h06, 8);
    sf(40'h60, 8);
    st(16'h0003);
    idle();
    st(16'h0000);
    wrsr(16'h0180);
    idle();
    st(16'h0180);
    wrsr(16'h0000);
    st(16'h0182);
    pwr();
    st(16'h0180);
    report_and_stop();
  end
endmodule
